// File: hdl/ers_pkg.sv
package ers_pkg;
   // Register byte offsets
   localparam logic [3:0]  ERS_OFF_STATUS    = 4'h0;
   localparam logic [3:0]  ERS_OFF_ADDR_LO   = 4'h4;
   localparam logic [3:0]  ERS_OFF_ADDR_HI   = 4'h8;
   localparam logic [3:0]  ERS_OFF_MISC_LO   = 4'hc;
   // Second block of offsets
   localparam logic [4:0]  ERS_OFF_MISC_HI   = 5'h10;
   localparam logic [4:0]  ERS_OFF_IRQ_STAT  = 5'h14;
   localparam logic [4:0]  ERS_OFF_IRQ_MASK  = 5'h18;
   // Status field positions
   localparam int          ERS_BIT_AV        = 31;
   localparam int          ERS_BIT_V         = 30;
   localparam int          ERS_BIT_UE        = 29;
   localparam int          ERS_BIT_OF        = 27;
   localparam int          ERS_BIT_MV        = 26;
   localparam int          ERS_CODE_LSB      = 0;
   localparam int          ERS_CODE_W        = 8;
   // Error codes
   localparam logic [7:0]  ERS_CODE_NONE     = 8'h00;
   localparam logic [7:0]  ERS_CODE_DECODE   = 8'h0d;
   localparam logic [7:0]  ERS_CODE_SLVERR   = 8'h12;
   localparam logic [7:0]  ERS_CODE_TIMEOUT  = 8'h14;
   // Interrupt bits
   localparam int          ERS_IRQ_LOGGED    = 0;
   localparam int          ERS_IRQ_OVERFLOW  = 1;
   localparam int          ERS_IRQ_W         = 2;
   localparam logic [31:0] ERS_RST_WORD      = 32'h0000_0000;
   localparam logic [1:0]  ERS_RST_MASK      = 2'h3;
   // Error kinds offered by the detector
   typedef enum logic [1:0] {
      ERS_KIND_DECODE,
      ERS_KIND_SLVERR,
      ERS_KIND_TIMEOUT,
      ERS_KIND_OTHER
   } ers_kind_type;
endpackage

// File: hdl/ers_error_record.sv
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Address-valid is 1 only while the address log holds the logged address.
// R2: Address-valid W1C; ignored while uncorrected set unless also cleared.
// R3: Record-valid sets on first error; W1C with same uncorrected interlock.
// R4: Uncorrected flag set when an error was neither corrected nor deferred.
// R5: Uncorrected W1C; ignored while overflow set unless also cleared.
// R6: Uncorrected reads meaningless while record-valid is zero.
// R7: Overflow sets when a second error arrives while one is held; W1C.
// R8: Misc-valid reads 1 while misc info logs hold details of the error.
// R9: Misc-valid W1C; ignored while uncorrected set unless also cleared.
// R10: Error code 00 no error, 13 decode error.
// R11: Error code 18 slave error response, 20 internal timeout.
// R12: Without error logging, overflow never sets; code only none or timeout.
// R13: Fault address log captures full 64-bit address, low word bits 31:0.
// R14: Reserved status bits read zero and ignore writes.
// R15: Error code read-only, held until record cleared and new error captured; the code sets it to 00 when record-valid is cleared.
module ers_error_record
   import ers_pkg::*;
#(
   parameter bit ERR_LOG_EN = 1'b1,
   parameter int ADDR_W     = 64
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic               clk_en,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [4:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               err_valid,
   input  wire ers_kind_type       err_kind,
   input  wire logic               err_uncorrected,
   input  wire logic [ADDR_W-1:0]  err_addr,
   input  wire logic               err_addr_ok,
   input  wire logic [31:0]        err_misc_lo,
   input  wire logic [31:0]        err_misc_hi,
   input  wire logic               err_misc_ok,
   output logic                    irq
);

   // Refused at elaboration: the address log is two words wide, and the
   // code field must stay clear of the flag bits above it
   if (ADDR_W < 33 || ADDR_W > 64) begin : g_bad_addr_w
      $error("ADDR_W must lie in 33..64");
   end
   if (ERS_CODE_LSB + ERS_CODE_W > ERS_BIT_MV) begin : g_bad_code_field
      $error("error code field overlaps the status flags");
   end
   if (ERS_IRQ_W != 2) begin : g_bad_irq_w
      $error("interrupt logic serves exactly two events");
   end

   logic              av_r, av_nxt;
   logic              v_r, v_nxt;
   logic              ue_r, ue_nxt;
   logic              of_r, of_nxt;
   logic              mv_r, mv_nxt;
   logic [7:0]        code_r, code_nxt;
   logic [63:0]       addr_r, addr_nxt;
   logic [31:0]       mlo_r, mlo_nxt;
   logic [31:0]       mhi_r, mhi_nxt;
   logic [1:0]        ist_r, ist_nxt;
   logic [1:0]        imsk_r, imsk_nxt;
   logic              ack_r, ack_nxt;
   logic [31:0]       rdat_r, rdat_nxt;

   logic              req;
   logic              wr;
   logic [31:0]       wmask;
   logic [31:0]       wv;
   logic              capture;
   logic              ovf_evt;
   logic [7:0]        new_code;
   logic              at_status;
   logic              at_irq_stat;
   logic              at_irq_mask;
   logic              clr_av;
   logic              clr_v;
   logic              clr_ue;
   logic              clr_of;
   logic              clr_mv;
   logic              ue_lock;
   logic [31:0]       st_word;

   function automatic logic [7:0] kind_code(input ers_kind_type k);
      kind_code = ERS_CODE_NONE;
      unique case (k)
         ERS_KIND_DECODE:  kind_code = ERS_CODE_DECODE;   // R10
         ERS_KIND_SLVERR:  kind_code = ERS_CODE_SLVERR;   // R11
         ERS_KIND_TIMEOUT: kind_code = ERS_CODE_TIMEOUT;  // R11
         // Unclassified faults are reported as a slave error
         ERS_KIND_OTHER:   kind_code = ERS_CODE_SLVERR;   // R11
      endcase
   endfunction

   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic [63:0] widen_addr(input logic [ADDR_W-1:0] a);
      logic [63:0] t;
      t = '0;
      t[ADDR_W-1:0] = a;
      widen_addr = t;
   endfunction

   // Full five-bit match, so a short offset has no alias higher up
   function automatic logic reg_is(input logic [4:0] a,
                                   input logic [4:0] off);
      reg_is = (a == off);
   endfunction

   assign req   = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr    = req && wb_we_i;
   assign wmask = lane_mask(wb_sel_i);
   assign wv    = wb_dat_i & wmask;
   assign at_status   = reg_is(wb_adr_i, 5'(ERS_OFF_STATUS));
   assign at_irq_stat = reg_is(wb_adr_i, ERS_OFF_IRQ_STAT);
   assign at_irq_mask = reg_is(wb_adr_i, ERS_OFF_IRQ_MASK);

   // Without error logging only timeouts reach the record
   always_comb begin
      new_code = kind_code(err_kind);
      capture  = 1'b0;
      ovf_evt  = 1'b0;
      if (err_valid &&
          (ERR_LOG_EN || err_kind == ERS_KIND_TIMEOUT)) begin // R12
         if (!v_r)
            capture = 1'b1;
         else if (ERR_LOG_EN)
            ovf_evt = 1'b1; // R7
      end
   end

   // Write-one-to-clear after the interlocks: an uncorrected error guards
   // the other valid bits, and an overflow guards the uncorrected flag
   always_comb begin
      clr_of  = 1'b0;
      clr_ue  = 1'b0;
      ue_lock = 1'b0;
      clr_av  = 1'b0;
      clr_v   = 1'b0;
      clr_mv  = 1'b0;
      if (wr && at_status) begin
         clr_of  = wv[ERS_BIT_OF]; // R7
         clr_ue  = wv[ERS_BIT_UE] && (!of_r || clr_of); // R5
         ue_lock = ue_r && !clr_ue;
         clr_av  = wv[ERS_BIT_AV] && !ue_lock; // R2
         clr_v   = wv[ERS_BIT_V] && !ue_lock; // R3
         clr_mv  = wv[ERS_BIT_MV] && !ue_lock; // R9
      end
   end

   // Record flags; a new event wins over a clear in the same cycle
   always_comb begin
      av_nxt   = av_r;
      v_nxt    = v_r;
      ue_nxt   = ue_r;
      of_nxt   = of_r;
      mv_nxt   = mv_r;
      code_nxt = code_r;
      addr_nxt = addr_r;
      mlo_nxt  = mlo_r;
      mhi_nxt  = mhi_r;
      if (clr_of)
         of_nxt = 1'b0; // R7
      if (clr_ue)
         ue_nxt = 1'b0; // R5
      if (clr_av)
         av_nxt = 1'b0; // R2
      if (clr_v) begin
         // The code is kept until the record is emptied
         v_nxt    = 1'b0; // R3
         code_nxt = ERS_CODE_NONE; // R15
      end
      if (clr_mv)
         mv_nxt = 1'b0; // R9
      if (capture) begin
         v_nxt    = 1'b1; // R3
         ue_nxt   = err_uncorrected; // R4
         code_nxt = new_code; // R15
         av_nxt   = err_addr_ok; // R1
         mv_nxt   = err_misc_ok; // R8
         if (err_addr_ok)
            addr_nxt = widen_addr(err_addr); // R13
         if (err_misc_ok) begin
            mlo_nxt = err_misc_lo;
            mhi_nxt = err_misc_hi;
         end
      end
      if (ovf_evt) begin
         of_nxt = 1'b1; // R7
         if (err_uncorrected)
            ue_nxt = 1'b1; // R4
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         av_r   <= 1'b0;
         v_r    <= 1'b0;
         ue_r   <= 1'b0;
         of_r   <= 1'b0;
         mv_r   <= 1'b0;
         code_r <= ERS_CODE_NONE;
         addr_r <= 64'h0;
         mlo_r  <= 32'h0;
         mhi_r  <= 32'h0;
      end else if (clk_en) begin
         av_r   <= av_nxt;
         v_r    <= v_nxt;
         ue_r   <= ue_nxt;
         of_r   <= of_nxt;
         mv_r   <= mv_nxt;
         code_r <= code_nxt;
         addr_r <= addr_nxt;
         mlo_r  <= mlo_nxt;
         mhi_r  <= mhi_nxt;
      end
   end

   // Interrupt status and mask. An error pulse while clk_en is low is
   // lost along with everything else; the detector must not fire then.
   always_comb begin
      ist_nxt  = ist_r;
      imsk_nxt = imsk_r;
      if (wr && at_irq_stat)
         ist_nxt = ist_r & ~wv[ERS_IRQ_W-1:0];
      if (wr && at_irq_mask)
         imsk_nxt = (imsk_r & ~wmask[ERS_IRQ_W-1:0]) | wv[ERS_IRQ_W-1:0];
      // Events come after the clear, so one in the same cycle survives
      if (capture)
         ist_nxt[ERS_IRQ_LOGGED] = 1'b1;
      if (ovf_evt)
         ist_nxt[ERS_IRQ_OVERFLOW] = 1'b1;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ist_r  <= 2'h0;
         imsk_r <= ERS_RST_MASK;
      end else if (clk_en) begin
         ist_r  <= ist_nxt;
         imsk_r <= imsk_nxt;
      end
   end

   // A one in the mask blocks the event; a blocked event stays pending
   // and raises the line as soon as it is unmasked
   assign irq = |(ist_r & ~imsk_r);

   // Status image as software reads it; all other bits stay zero
   always_comb begin
      st_word = ERS_RST_WORD; // R14
      st_word[ERS_BIT_AV] = av_r; // R1
      st_word[ERS_BIT_V]  = v_r; // R3
      // Meaningless while the record is empty; forced low so that an
      // empty record always reads the uncorrected flag as zero; the code reads zero because clearing the record loads 00
      st_word[ERS_BIT_UE] = ue_r & v_r; // R6
      st_word[ERS_BIT_OF] = of_r; // R7
      st_word[ERS_BIT_MV] = mv_r; // R8
      st_word[ERS_CODE_LSB +: ERS_CODE_W] = code_r; // R10
   end

   // Bus answer: one cycle after the request, unmapped reads zero.
   // Zero outside an answer keeps stale data off a shared return bus.
   always_comb begin
      ack_nxt  = req;
      rdat_nxt = ERS_RST_WORD;
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            5'(ERS_OFF_STATUS):  rdat_nxt = st_word;
            5'(ERS_OFF_ADDR_LO): rdat_nxt = addr_r[31:0]; // R13
            5'(ERS_OFF_ADDR_HI): rdat_nxt = addr_r[63:32];
            5'(ERS_OFF_MISC_LO): rdat_nxt = mlo_r;
            ERS_OFF_MISC_HI:     rdat_nxt = mhi_r;
            ERS_OFF_IRQ_STAT:    rdat_nxt[ERS_IRQ_W-1:0] = ist_r;
            ERS_OFF_IRQ_MASK:    rdat_nxt[ERS_IRQ_W-1:0] = imsk_r;
            default:             rdat_nxt = ERS_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ack_r  <= 1'b0;
         rdat_r <= 32'h0;
      end else if (clk_en) begin
         ack_r  <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

endmodule
`default_nettype wire

// File: bench/ers_error_record_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ers_error_record_checker (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o
);
   logic take;
   logic st_rd_r;
   logic st_rd;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
   // Status fields only mean something in the answer to a status read
   assign st_rd = wb_ack_o && st_rd_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st_rd_r <= 1'b0;
      end else if (clk_en) begin
         st_rd_r <= take && !wb_we_i && wb_adr_i == 5'h00;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_ack_answer: assert property (take |=> wb_ack_o)
      else $error("request not answered");
   a_ack_pulse: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(take))
      else $error("ack without request");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside answer");
   a_reserved_zero: assert property (
      st_rd |-> !wb_dat_o[28] && wb_dat_o[25:8] == 18'h0)
      else $error("reserved status bits set");
   a_code_legal: assert property (
      st_rd |-> wb_dat_o[7:0] inside {8'h00, 8'h0d, 8'h12, 8'h14})
      else $error("undefined error code");
   a_ue_invalid: assert property (
      st_rd && !wb_dat_o[30] |-> !wb_dat_o[29] && wb_dat_o[7:0] == 8'h0)
      else $error("fields set in empty record");
   a_code_valid: assert property (
      st_rd && wb_dat_o[30] |-> wb_dat_o[7:0] != 8'h00)
      else $error("valid record without code");
endmodule
`default_nettype wire

// File: bench/ers_error_record_test.sv
`timescale 1ns/1ps
`default_nettype none
module ers_error_record_test
   import ers_pkg::*;
;
   logic         clock = 1'b0, rst = 1'b1, en = 1'b1, ack, irq;
   logic         cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic         ev = 1'b0, unc = 1'b0, aok = 1'b0;
   logic [4:0]   adr = 5'h0;
   logic [31:0]  wd = 32'h0, rd, got, mlo = 32'h0;
   logic [63:0]  ea = 64'h0;
   ers_kind_type kind = ERS_KIND_DECODE;
   int           n_mismatch = 0, tests_run = 0;
   logic [7:0]   codes [4] = '{ERS_CODE_DECODE, ERS_CODE_SLVERR,
                               ERS_CODE_TIMEOUT, ERS_CODE_SLVERR};
   ers_error_record dut_u (.clock(clock), .rst(rst), .clk_en(en),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .err_valid(ev), .err_kind(kind), .err_uncorrected(unc),
      .err_addr(ea), .err_addr_ok(aok), .err_misc_lo(mlo),
      .err_misc_hi(~mlo), .err_misc_ok(aok), .irq(irq));
   initial forever #12.5 clock = ~clock;
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      do @(posedge clock); while (ack !== 1'b1);
      got = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(got, e);
   endtask
   task automatic hit(input ers_kind_type k, input logic u, input logic ok);
      @(posedge clock);
      ev <= 1'b1;
      kind <= k;
      unc <= u;
      aok <= ok;
      ea <= 64'h1234_5678_9abc_de00 + 64'(k);
      mlo <= 32'h5a5a_0000 + 32'(k);
      @(posedge clock);
      ev <= 1'b0;
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rdc(5'h00, 32'h0);
      rdc(5'h18, 32'h3);
      bus(1'b1, 5'h1c, 32'hffff_ffff);
      rdc(5'h1c, 32'h0);
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         hit(ers_kind_type'(k), 1'b0, 1'b1);
         rdc(5'h00, 32'hc400_0000 | codes[k]);
         rdc(5'h04, 32'h9abc_de00 + 32'(k));
         rdc(5'h08, 32'h1234_5678);
         rdc(5'h0c, 32'h5a5a_0000 + 32'(k));
         rdc(5'h10, ~(32'h5a5a_0000 + 32'(k)));
         bus(1'b1, 5'h00, 32'hffff_ffff);
         rdc(5'h00, 32'h0);
      end
      $display("test codes done");
      hit(ERS_KIND_DECODE, 1'b1, 1'b0);
      rdc(5'h00, 32'h6000_000d);
      bus(1'b1, 5'h00, 32'hc400_0000);
      rdc(5'h00, 32'h6000_000d);
      hit(ERS_KIND_TIMEOUT, 1'b0, 1'b0);
      rdc(5'h00, 32'h6800_000d);
      bus(1'b1, 5'h00, 32'h2000_0000);
      rdc(5'h00, 32'h6800_000d);
      bus(1'b1, 5'h00, 32'h2800_0000);
      rdc(5'h00, 32'h4000_000d);
      $display("test interlock done");
      rdc(5'h14, 32'h3);
      bus(1'b1, 5'h18, 32'h0);
      chk(32'(irq), 32'h1);
      bus(1'b1, 5'h14, 32'h1);
      chk(32'(irq), 32'h1);
      bus(1'b1, 5'h14, 32'h2);
      chk(32'(irq), 32'h0);
      bus(1'b1, 5'h00, 32'h4000_0000);
      rdc(5'h00, 32'h0);
      hit(ERS_KIND_SLVERR, 1'b0, 1'b0);
      rdc(5'h14, 32'h1);
      chk(32'(irq), 32'h1);
      bus(1'b1, 5'h18, 32'h1);
      chk(32'(irq), 32'h0);
      $display("test interrupt done");
      // A second error while frozen must leave the held record alone
      en <= 1'b0;
      hit(ERS_KIND_DECODE, 1'b1, 1'b1);
      en <= 1'b1;
      rdc(5'h00, 32'h4000_0012);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rdc(5'h00, 32'h0);
      rdc(5'h18, 32'h3);
      chk(32'(irq), 32'h0);
      $display("test enable and reset done");
      close_out();
   end
   // Generous bound: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      close_out();
   end
endmodule
bind ers_error_record ers_error_record_checker chk_u (.clock(clock),
   .rst(rst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o));
`default_nettype wire
